/* File: common/reclose_sup_pkg.sv */
/*
  reclose_sup_pkg: constants, register map and carrier types for the
  recloser supervision block.
  assumes: one 25 MHz clock, 32-bit AHB-Lite register bus, voltages in
  tenths of a volt, a periodic tick supplied from outside.

*/
package reclose_sup_pkg;
  // ------------------------------------------------------------
  // sizes and encodings
  // ------------------------------------------------------------
  localparam int unsigned IDX_W       = 7;
  localparam int unsigned NUM_IDX     = 128;
  localparam int unsigned SEL_W       = 8;
  localparam int unsigned SEL_INV_BIT = 7;    // "+1000": contact closed at rest
  localparam int unsigned VOLT_W      = 12;   // tenths of a volt
  localparam int unsigned NUM_CONTACT = 24;
  localparam int unsigned NUM_ALARM   = 8;
  localparam logic [IDX_W-1:0] ALARM_IDX = 7'd52;
  localparam logic [23:0] SINGLE_ONLY_MASK = 24'h03_C030;  // contacts 4,5,14-17

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_WAIT      = 8'h04;
  localparam logic [7:0] OFS_BUS_TH    = 8'h08;
  localparam logic [7:0] OFS_LINE_TH   = 8'h0C;
  localparam logic [7:0] OFS_LIMITS    = 8'h10;
  localparam logic [7:0] OFS_ALARM_LO  = 8'h14;
  localparam logic [7:0] OFS_ALARM_HI  = 8'h18;
  localparam logic [7:0] OFS_TRIP_OSC  = 8'h1C;
  localparam logic [7:0] OFS_STATUS    = 8'h20;
  localparam logic [7:0] OFS_CONTACT0  = 8'h40;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned CTRL_MASTER  = 0;
  localparam int unsigned CTRL_MANUAL  = 1;
  localparam int unsigned CTRL_SP1     = 2;  // bits 2..4, attempts 2..4
  localparam int unsigned CTRL_SP3     = 5;  // bits 5..8, attempts 1..4
  localparam int unsigned CTRL_LBDL    = 9;
  localparam int unsigned CTRL_DBLL    = 10;
  localparam int unsigned CTRL_DBDL    = 11;
  localparam int unsigned CTRL_DVBLK   = 12;
  localparam int unsigned CTRL_W       = 13;
  localparam int unsigned DEAD_LSB     = 16;
  localparam int unsigned ANGLE_LSB    = 16;
  localparam int unsigned SLIP_LSB     = 24;
  localparam int unsigned ST_LOCKOUT   = 6;
  localparam int unsigned ST_LOGGED    = 9;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;
  localparam logic [6:0]  WAIT_RST  = 7'h0A;    // seconds
  localparam logic [11:0] LIVE_RST  = 12'h2BC;  // 70.0 V
  localparam logic [11:0] DEAD_RST  = 12'h0C8;  // 20.0 V
  localparam logic [8:0]  DIFF_RST  = 9'h064;   // 10.0 V
  localparam logic [6:0]  ANGLE_RST = 7'h14;    // degrees
  localparam logic [5:0]  SLIP_RST  = 6'h01;    // tenths of a hertz
  localparam logic [NUM_CONTACT*SEL_W-1:0] CONTACT_RST =
    192'h3635_2827_0000_0000_0000_0000_0000_0000_0000_0000_0000_0000;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } close_state_e;

  typedef struct packed {
    logic       valid;    // one-cycle request
    logic       manual;   // manual close command
    logic       single;   // cycle began with single-pole trip
    logic [1:0] attempt;  // 0 = first attempt
  } close_req_s;

  typedef struct packed {
    logic [VOLT_W-1:0] bus;
    logic [VOLT_W-1:0] line;
    logic [6:0]        angle;  // degrees
    logic [5:0]        slip;   // tenths of a hertz
  } measure_s;

  typedef struct packed {
    logic             we;
    logic [4:0]       contact;
    logic [SEL_W-1:0] sel;
  } cfg_write_s;
endpackage : reclose_sup_pkg

/* File: hw/reclose_sync_supervision.sv */
/*
  reclose_sync_supervision: sync-check and live/dead supervision of
  reclose and manual close, minor alarm, contact mapping, trip and
  capture triggers, with an AHB-Lite settings slave.
  assumes: inputs synchronous to hclk, tick is a one-cycle pulse,
  measurements are stable between ticks.
*/
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module reclose_sync_supervision
  import reclose_sup_pkg::*;
#(
  parameter int unsigned TICKS_PER_SEC = 10,
  parameter bit          SINGLE_PHASE  = 1'b1
) (
  // clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // measurement and scheme signals
  input  wire logic                   tick,
  input  wire measure_s               meas,
  input  wire logic [NUM_IDX-1:0]     sig_in,
  input  wire logic                   trip_in,
  // close requests
  input  wire close_req_s             close_req,
  // configurable logic path
  input  wire cfg_write_s             cfg_wr,
  // outputs
  output logic                        close_permit,
  output logic                        lockout,
  output logic                        sync_waiting,
  output logic                        volt_diff,
  output logic                        minor_alarm,
  output logic                        alarm_event,
  output logic [NUM_CONTACT-1:0]      contact_out,
  output logic                        trip3p_out,
  output logic                        capture_start
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // selected signal with optional inversion; index zero is unused
  function automatic logic sel_lookup(input logic [NUM_IDX-1:0] v, input logic [SEL_W-1:0] s);
    logic [IDX_W-1:0] idx;
    idx = s[IDX_W-1:0];
    sel_lookup = (idx == '0) ? 1'b0 : (v[idx] ^ s[SEL_INV_BIT]);
  endfunction : sel_lookup

  // sign-free magnitude difference of two voltages
  function automatic logic [VOLT_W-1:0] abs_diff(input logic [VOLT_W-1:0] a, input logic [VOLT_W-1:0] b);
    abs_diff = (a > b) ? (a - b) : (b - a);
  endfunction : abs_diff

  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] TICKS_SEC = CNT_W'(TICKS_PER_SEC);

  // ------------------------------------------------------------
  // settings store
  // ------------------------------------------------------------
  logic [CTRL_W-1:0]  ctrl_reg;
  logic [6:0]         sync_wait_time;
  logic [11:0]        bus_live_threshold;
  logic [11:0]        bus_dead_threshold;
  logic [11:0]        line_live_threshold;
  logic [11:0]        line_dead_threshold;
  logic [8:0]         voltage_diff_threshold;
  logic [6:0]         closing_angle_limit;
  logic [5:0]         slip_frequency_limit;
  logic [SEL_W-1:0]   alarm_sel_reg [NUM_ALARM];
  logic [SEL_W-1:0]   config_trip_select;
  logic [SEL_W-1:0]   capture_trigger_select;
  logic [SEL_W-1:0]   contact_sel_reg [NUM_CONTACT];

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic               bus_live, bus_dead, line_live, line_dead, sync_ok;
  logic               alarm_logged_reg;
  close_state_e       state_reg;
  logic [CNT_W-1:0]   wait_cnt_reg;
  logic               lockout_clr, logged_clr;
  logic [NUM_IDX-1:0] sig_vec;
  logic               req_sup, dl_permit, trip_now;
  logic               alarm_next;

  // ------------------------------------------------------------
  // bus address phase
  // ------------------------------------------------------------
  logic               wr_pend_reg;
  logic [7:0]         wr_addr_reg;
  logic               acc_now;
  logic [7:0]         acc_ofs;

  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay
  assign acc_now   = hsel & hready & htrans[1];
  assign acc_ofs   = haddr[7:0];

  // capture write address for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (hready) begin
      wr_pend_reg <= acc_now & hwrite & (haddr[31:8] == '0);
      wr_addr_reg <= acc_ofs;
    end
  end

  // read data registered at the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (acc_now & ~hwrite) begin
      hrdata <= '0;
      if (haddr[31:8] == '0) begin
        case (acc_ofs)
          OFS_CTRL:     hrdata <= 32'(ctrl_reg);
          OFS_WAIT:     hrdata <= 32'(sync_wait_time);
          OFS_BUS_TH:   hrdata <= {4'h0, bus_dead_threshold, 4'h0, bus_live_threshold};
          OFS_LINE_TH:  hrdata <= {4'h0, line_dead_threshold, 4'h0, line_live_threshold};
          OFS_LIMITS:   hrdata <= {2'b00, slip_frequency_limit, 1'b0, closing_angle_limit,
                                   7'h00, voltage_diff_threshold};
          OFS_ALARM_LO: hrdata <= {alarm_sel_reg[3], alarm_sel_reg[2], alarm_sel_reg[1], alarm_sel_reg[0]};
          OFS_ALARM_HI: hrdata <= {alarm_sel_reg[7], alarm_sel_reg[6], alarm_sel_reg[5], alarm_sel_reg[4]};
          OFS_TRIP_OSC: hrdata <= {16'h0000, capture_trigger_select, config_trip_select};
          OFS_STATUS:   hrdata <= {22'h00_0000, alarm_logged_reg, minor_alarm, sync_waiting, lockout,
                                   volt_diff, sync_ok, line_dead, line_live, bus_dead, bus_live};
          default: begin
            if (acc_ofs >= OFS_CONTACT0 && acc_ofs < OFS_CONTACT0 + 8'(4 * NUM_CONTACT) && acc_ofs[1:0] == 2'b00)
              hrdata <= 32'(contact_sel_reg[5'((acc_ofs - OFS_CONTACT0) >> 2)]);
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // settings writes
  // ------------------------------------------------------------
  // scalar settings, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg               <= CTRL_RST;
      sync_wait_time         <= WAIT_RST;
      bus_live_threshold     <= LIVE_RST;
      bus_dead_threshold     <= DEAD_RST;
      line_live_threshold    <= LIVE_RST;
      line_dead_threshold    <= DEAD_RST;
      voltage_diff_threshold <= DIFF_RST;
      closing_angle_limit    <= ANGLE_RST;
      slip_frequency_limit   <= SLIP_RST;
      config_trip_select     <= '0;
      capture_trigger_select <= '0;
      for (int i = 0; i < NUM_ALARM; i++) alarm_sel_reg[i] <= '0;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        OFS_CTRL:    ctrl_reg       <= hwdata[CTRL_W-1:0];
        OFS_WAIT:    sync_wait_time <= hwdata[6:0];
        OFS_BUS_TH: begin
          bus_live_threshold <= hwdata[11:0];
          bus_dead_threshold <= hwdata[DEAD_LSB +: 12];
        end
        OFS_LINE_TH: begin
          line_live_threshold <= hwdata[11:0];
          line_dead_threshold <= hwdata[DEAD_LSB +: 12];
        end
        OFS_LIMITS: begin
          voltage_diff_threshold <= hwdata[8:0];
          closing_angle_limit    <= hwdata[ANGLE_LSB +: 7];
          slip_frequency_limit   <= hwdata[SLIP_LSB +: 6];
        end
        OFS_ALARM_LO: for (int i = 0; i < 4; i++) alarm_sel_reg[i] <= hwdata[i*SEL_W +: SEL_W];
        OFS_ALARM_HI: for (int i = 0; i < 4; i++) alarm_sel_reg[i+4] <= hwdata[i*SEL_W +: SEL_W];
        OFS_TRIP_OSC: begin
          config_trip_select     <= hwdata[7:0];
          capture_trigger_select <= hwdata[15:8];
        end
        default: ;
      endcase
    end
  end

  // one contact store shared by bus and logic paths; logic path wins a tie
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CONTACT; i++) contact_sel_reg[i] <= CONTACT_RST[i*SEL_W +: SEL_W];
    end else if (cfg_wr.we && cfg_wr.contact < 5'(NUM_CONTACT)) begin
      contact_sel_reg[cfg_wr.contact] <= cfg_wr.sel;
    end else if (wr_pend_reg && wr_addr_reg >= OFS_CONTACT0 && wr_addr_reg < OFS_CONTACT0 + 8'(4 * NUM_CONTACT)
                 && wr_addr_reg[1:0] == 2'b00) begin
      contact_sel_reg[5'((wr_addr_reg - OFS_CONTACT0) >> 2)] <= hwdata[SEL_W-1:0];
    end
  end

  // write-one-to-clear on the status word
  assign lockout_clr = wr_pend_reg && (wr_addr_reg == OFS_STATUS) && hwdata[ST_LOCKOUT];
  assign logged_clr  = wr_pend_reg && (wr_addr_reg == OFS_STATUS) && hwdata[ST_LOGGED];

  // ------------------------------------------------------------
  // voltage supervision, sampled on the tick
  // ------------------------------------------------------------
  // evaluating only on the tick keeps the decisions steady between samples
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_live  <= 1'b0;
      bus_dead  <= 1'b0;
      line_live <= 1'b0;
      line_dead <= 1'b0;
      volt_diff <= 1'b0;
      sync_ok   <= 1'b0;
    end else if (tick) begin
      bus_live  <= meas.bus > bus_live_threshold;
      bus_dead  <= meas.bus < bus_dead_threshold;
      line_live <= meas.line > line_live_threshold;
      line_dead <= meas.line < line_dead_threshold;
      volt_diff <= abs_diff(meas.bus, meas.line) >= VOLT_W'(voltage_diff_threshold);
      sync_ok   <= (meas.bus > bus_live_threshold) && (meas.line > line_live_threshold)
                   && (meas.angle <= closing_angle_limit) && (meas.slip < slip_frequency_limit)
                   && !(ctrl_reg[CTRL_DVBLK]
                        && abs_diff(meas.bus, meas.line) >= VOLT_W'(voltage_diff_threshold));
    end
  end

  // live/dead combinations that allow a close without sync check
  assign dl_permit = (ctrl_reg[CTRL_LBDL] & line_dead & bus_live)
                   | (ctrl_reg[CTRL_DBLL] & line_live & bus_dead)
                   | (ctrl_reg[CTRL_DBDL] & line_dead & bus_dead);

  // ------------------------------------------------------------
  // supervision flag for the requested close
  // ------------------------------------------------------------
  always_comb begin
    if (close_req.manual) begin
      req_sup = ctrl_reg[CTRL_MANUAL];
    end else if (close_req.single) begin
      // first attempt after a single-pole trip is single-pole and not supervised
      req_sup = ctrl_reg[CTRL_MASTER] && (close_req.attempt != 2'd0)
                && ctrl_reg[CTRL_SP1 + 32'(close_req.attempt) - 1];
    end else begin
      req_sup = ctrl_reg[CTRL_MASTER] && ctrl_reg[CTRL_SP3 + 32'(close_req.attempt)];
    end
  end

  // ------------------------------------------------------------
  // close supervision sequencer
  // ------------------------------------------------------------
  // requests while waiting or locked out are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= ST_IDLE;
      wait_cnt_reg <= '0;
      close_permit <= 1'b0;
    end else begin
      close_permit <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          wait_cnt_reg <= '0;
          if (close_req.valid && !lockout) begin
            if (!req_sup || dl_permit || sync_ok) close_permit <= 1'b1;
            else state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (dl_permit || sync_ok) begin
            close_permit <= 1'b1;
            wait_cnt_reg <= '0;
            state_reg    <= ST_IDLE;
          end else if (wait_cnt_reg >= CNT_W'(sync_wait_time) * TICKS_SEC) begin
            state_reg <= ST_IDLE;
          end else if (tick) begin
            wait_cnt_reg <= wait_cnt_reg + 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign sync_waiting = (state_reg == ST_WAIT);

  // lockout is sticky; expiry wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lockout <= 1'b0;
    end else if (state_reg == ST_WAIT && !(dl_permit || sync_ok)
                 && wait_cnt_reg >= CNT_W'(sync_wait_time) * TICKS_SEC) begin
      lockout <= 1'b1;
    end else if (lockout_clr) begin
      lockout <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // minor alarm
  // ------------------------------------------------------------
  // the registered alarm feeds index 52 so selecting it cannot loop
  always_comb begin
    sig_vec            = sig_in;
    sig_vec[ALARM_IDX] = minor_alarm;
  end

  // any of the eight selected signals raises the alarm
  assign alarm_next = sel_lookup(sig_vec, alarm_sel_reg[0]) | sel_lookup(sig_vec, alarm_sel_reg[1])
                    | sel_lookup(sig_vec, alarm_sel_reg[2]) | sel_lookup(sig_vec, alarm_sel_reg[3])
                    | sel_lookup(sig_vec, alarm_sel_reg[4]) | sel_lookup(sig_vec, alarm_sel_reg[5])
                    | sel_lookup(sig_vec, alarm_sel_reg[6]) | sel_lookup(sig_vec, alarm_sel_reg[7]);

  // event pulse on every rise of the alarm, whichever slot raised it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      minor_alarm <= 1'b0;
      alarm_event <= 1'b0;
    end else begin
      minor_alarm <= alarm_next;
      alarm_event <= alarm_next & ~minor_alarm;
    end
  end

  // event log flag: set wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_logged_reg <= 1'b0;
    end else if (minor_alarm) begin
      alarm_logged_reg <= 1'b1;
    end else if (logged_clr) begin
      alarm_logged_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // contacts, trip and capture
  // ------------------------------------------------------------
  assign trip_now = sel_lookup(sig_vec, config_trip_select);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      contact_out   <= '0;
      trip3p_out    <= 1'b0;
      capture_start <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CONTACT; i++)
        contact_out[i] <= sel_lookup(sig_vec, contact_sel_reg[i])
                          & (SINGLE_PHASE | ~SINGLE_ONLY_MASK[i]);
      trip3p_out    <= trip_now;
      // trips always capture, even if a noisy trigger is also selected
      capture_start <= sel_lookup(sig_vec, capture_trigger_select) | trip_now | trip_in;
    end
  end

endmodule : reclose_sync_supervision
`default_nettype wire

/* File: verif/reclose_sup_props.sv */
/*
  reclose_sup_props: port assertions on the recloser supervision block.
  assumes: bound to reclose_sync_supervision, one clock hclk.
*/
`timescale 1ns/1ns
`default_nettype none
module reclose_sup_props
  import reclose_sup_pkg::*;
(
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // watched ports
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       tick,
  input wire logic       trip_in,
  input wire close_req_s close_req,
  input wire logic       close_permit,
  input wire logic       lockout,
  input wire logic       sync_waiting,
  input wire logic       volt_diff,
  input wire logic       capture_start
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // close handshake steps
  // ----
  sequence req_taken;
    close_req.valid && !sync_waiting && !lockout;
  endsequence
  sequence answered;
    close_permit || sync_waiting;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or okay");
  a_permit_pulse: assert property (close_permit |=> !close_permit) else $error("permit wider than one cycle");
  a_permit_idle: assert property (close_permit |-> !sync_waiting && !lockout) else $error("permit while busy");
  a_req_answer: assert property (req_taken |=> ##[0:1] answered) else $error("request not answered");
  a_wait_ends: assert property ($fell(sync_waiting) |-> close_permit || lockout) else $error("wait left silently");
  a_lock_idle: assert property (lockout |-> !sync_waiting) else $error("waiting in lockout");
  a_capture_trip: assert property (trip_in |=> capture_start) else $error("trip gave no capture");
  a_diff_tick: assert property (!tick |=> $stable(volt_diff)) else $error("difference moved off tick");
endmodule : reclose_sup_props
bind reclose_sync_supervision reclose_sup_props u_props (.hclk, .hresetn, .hreadyout, .hresp, .tick, .trip_in,
  .close_req, .close_permit, .lockout, .sync_waiting, .volt_diff, .capture_start);
`default_nettype wire

/* File: verif/vt_source.sv */
/*
  vt_source: far-side model, voltage transformers and tick source.
  assumes: levels set by the bench, tick every eighth hclk.
*/
`timescale 1ns/1ns
`default_nettype none
module vt_source
  import reclose_sup_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // measured levels
  input  wire logic [11:0] bus_v,
  input  wire logic [11:0] line_v,
  input  wire logic [6:0]  ang,
  // to the block
  output logic             tick,
  output measure_s         meas
);
  logic [2:0] cnt_reg;
  // slow tick keeps status updates sparse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 3'h0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      tick    <= (cnt_reg == 3'h7);
    end
  end
  // slip held at zero, below any nonzero limit
  assign meas = '{bus: bus_v, line: line_v, angle: ang, slip: 6'h00};
endmodule : vt_source
`default_nettype wire

/* File: verif/tb_top.sv */
/*
  tb_top: self-checking bench for reclose_sync_supervision.
  assumes: vt_source gives tick and measurements.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import reclose_sup_pkg::*;
  typedef struct {logic [11:0] bv, lv; logic [6:0] ang; logic [12:0] ctrl; logic [3:0] req;
    logic [5:0] st; logic pm;} row_s;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, trip_in = 0, hreadyout, hresp, tick, got;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [11:0] bus_v = '0, line_v = '0;
  logic [6:0] ang = '0;
  logic [NUM_IDX-1:0] sig_in = '0;
  logic [23:0] contact_out;
  logic close_permit, lockout, sync_waiting, volt_diff, minor_alarm, alarm_event, trip3p_out, capture_start;
  close_req_s close_req = '0;
  cfg_write_s cfg_wr = '0;
  measure_s meas;
  int err_count = 0, num_checks = 0;
  row_s rows[13] = '{
    '{12'h2BD, 12'h0C7, 7'h32, 13'h0221, 4'h0, 6'h29, 1'b1},
    '{12'h2BC, 12'h0C7, 7'h32, 13'h0221, 4'h0, 6'h28, 1'b0},
    '{12'h064, 12'h320, 7'h32, 13'h0421, 4'h0, 6'h26, 1'b1},
    '{12'h064, 12'h096, 7'h32, 13'h0821, 4'h0, 6'h0A, 1'b1},
    '{12'h064, 12'h096, 7'h32, 13'h0221, 4'h0, 6'h0A, 1'b0},
    '{12'h320, 12'h320, 7'h0A, 13'h0021, 4'h0, 6'h15, 1'b1},
    '{12'h320, 12'h384, 7'h0A, 13'h1021, 4'h0, 6'h25, 1'b0},
    '{12'h320, 12'h384, 7'h0A, 13'h0021, 4'h0, 6'h35, 1'b1},
    '{12'h320, 12'h320, 7'h32, 13'h0020, 4'h0, 6'h05, 1'b1},
    '{12'h320, 12'h320, 7'h15, 13'h0021, 4'h0, 6'h05, 1'b0},
    '{12'h320, 12'h320, 7'h32, 13'h0021, 4'h5, 6'h05, 1'b1},
    '{12'h320, 12'h320, 7'h32, 13'h0025, 4'h5, 6'h05, 1'b0},
    '{12'h320, 12'h320, 7'h32, 13'h0002, 4'h8, 6'h05, 1'b0}};
  // clock and parts
  always #20 hclk = ~hclk;
  reclose_sync_supervision #(.TICKS_PER_SEC(2)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tick, .meas, .sig_in, .trip_in,
    .close_req, .cfg_wr, .close_permit, .lockout, .sync_waiting, .volt_diff, .minor_alarm, .alarm_event,
    .contact_out, .trip3p_out, .capture_start);
  vt_source u_vt (.hclk, .hresetn, .bus_v, .line_v, .ang, .tick, .meas);
  // ----
  // tasks
  // ----
  task print_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bounded wait for hready at an edge
  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    r = hrdata;
  endtask : xfer
  // a close request, then wait for permit or lockout
  task request(input logic [3:0] rq, output logic g);
    int n;
    close_req <= {1'b1, rq};
    @(posedge hclk);
    close_req <= '0;
    for (n = 0; n < 300; n++) begin
      @(posedge hclk);
      if (close_permit === 1'b1 || lockout === 1'b1) break;
    end
    if (n == 300) begin
      err_count++;
      print_verdict();
    end
    g = close_permit;
  endtask : request
  // ----
  // main sequence
  // ----
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, OFS_WAIT, 32'h0, rd);
    chk("wait reset", 32'h0000_000A, rd);
    xfer(1'b0, OFS_BUS_TH, 32'h0, rd);
    chk("bus th reset", 32'h00C8_02BC, rd);
    xfer(1'b0, 8'h90, 32'h0, rd);
    chk("contact 20 reset", 32'h0000_0027, rd);
    xfer(1'b0, 8'h3C, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    xfer(1'b1, OFS_WAIT, 32'h1, rd);
    foreach (rows[i]) begin
      bus_v <= rows[i].bv;
      line_v <= rows[i].lv;
      ang <= rows[i].ang;
      xfer(1'b1, OFS_CTRL, {19'h0_0000, rows[i].ctrl}, rd);
      repeat (20) @(posedge hclk);
      xfer(1'b0, OFS_STATUS, 32'h0, rd);
      chk("status", {26'h0, rows[i].st}, {26'h0, rd[5:0]});
      request(rows[i].req, got);
      chk("permit", {31'h0, rows[i].pm}, {31'h0, got});
      xfer(1'b1, OFS_STATUS, 32'h40, rd);
    end
    // supervised manual close waits, then sync arrives before expiry
    close_req <= 5'h18;  // valid, manual, no permission yet
    @(posedge hclk);
    close_req <= '0;
    @(posedge hclk);
    chk("waiting", 32'h1, {31'h0, sync_waiting});
    ang <= 7'h0A;
    got = 1'b0;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge hclk);
      got = close_permit;
    end
    chk("permit after wait", 32'h1, {31'h0, got});
    chk("wait over", 32'h0, {31'h0, sync_waiting});
    if (got !== 1'b1) print_verdict();
    // alarm slot 0 on index 10, contact 2 shows the alarm
    xfer(1'b1, OFS_ALARM_LO, 32'h0000_000A, rd);
    xfer(1'b1, 8'h48, 32'h0000_0034, rd);
    cfg_wr <= '{we: 1'b1, contact: 5'h00, sel: 8'h8B};
    xfer(1'b1, OFS_TRIP_OSC, 32'h0000_0C0B, rd);
    cfg_wr <= '0;
    sig_in[10] <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("alarm event", 32'h1, {31'h0, alarm_event});
    repeat (2) @(posedge hclk);
    chk("alarm", 32'h1, {31'h0, minor_alarm});
    chk("alarm contact", 32'h1, {31'h0, contact_out[2]});
    chk("inverted contact", 32'h1, {31'h0, contact_out[0]});
    xfer(1'b0, OFS_STATUS, 32'h0, rd);
    chk("logged", 32'h1, {31'h0, rd[ST_LOGGED]});
    xfer(1'b0, OFS_CONTACT0, 32'h0, rd);
    chk("cfg path", 32'h0000_008B, rd);
    sig_in[11] <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("trip", 32'h1, {31'h0, trip3p_out});
    chk("contact follows", 32'h0, {31'h0, contact_out[0]});
    sig_in[11] <= 1'b0;
    sig_in[12] <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("trip released", 32'h0, {31'h0, trip3p_out});
    chk("capture", 32'h1, {31'h0, capture_start});
    sig_in[12] <= 1'b0;
    trip_in <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("trip capture", 32'h1, {31'h0, capture_start});
    // reset in mid-run clears the alarm and reloads the contact store reset values
    hresetn <= 1'b0;
    @(posedge hclk);
    chk("reset alarm", 32'h0, {31'h0, minor_alarm});
    hresetn <= 1'b1;
    xfer(1'b0, OFS_CONTACT0, 32'h0, rd);
    chk("contact 0 reset", 32'h0, rd);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
